// File: hdl/cists_pkg.sv
package cists_pkg;

   // ==========================================================================
   // Register map (byte addresses on the Wishbone slave).
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_RESULT = 8'h04;
   localparam logic [7:0] ADDR_BUS_STATE = 8'h08;
   localparam logic [7:0] ADDR_DATA_IN = 8'h0C;
   localparam logic [7:0] ADDR_SWITCHES = 8'h10;

   // ==========================================================================
   // Command numbers.
   localparam logic [7:0] CMD_STATUS = 8'h1D;
   localparam logic [7:0] CMD_VERSION = 8'h1E;
   localparam logic [7:0] CMD_SET_SW = 8'h20;
   localparam logic [7:0] CMD_READ_SW = 8'h21;
   localparam logic [7:0] CMD_READ_DATA = 8'h01;

   // ==========================================================================
   // Command register field positions.
   localparam int CMD_CODE_LSB = 0;
   localparam int SW_REPEAT_BIT = 8;
   localparam int SW_IRQ_LSB = 12;
   localparam int SW_MODE_LSB = 16;

   // Bus state register field positions.
   localparam int ST_ACTIVE_BIT = 0;
   localparam int ST_REC_LSB = 8;
   localparam int ST_TEC_LSB = 16;

   // ==========================================================================
   // Status codes and thresholds.
   localparam logic [7:0] ERR_WARN_LEVEL = 8'h60;
   localparam logic [31:0] STAT_ACTIVE_OK = 32'h0000_0000;
   localparam logic [31:0] STAT_ACTIVE_ERR = 32'h0000_0001;
   localparam logic [31:0] STAT_IDLE_OK = 32'h0000_0002;
   localparam logic [31:0] STAT_IDLE_ERR = 32'h0000_0003;

   // Switch codes and reset values.
   localparam logic [3:0] SW_KEEP = 4'h9;
   localparam logic [3:0] IRQ_OFF = 4'h0;
   localparam logic [3:0] IRQ_PULSE = 4'h1;
   localparam logic [3:0] IRQ_FAST = 4'h2;
   localparam logic [3:0] IRQ_STANDBY = 4'h8;
   localparam logic [3:0] MODE_POWERUP = 4'h7;
   localparam logic REPEAT_RESET = 1'b0;

   // Marker returned for a stale read, two's complement of 99999.
   localparam logic [31:0] STALE_MARK = 32'hFFFE_7961;

   // ==========================================================================
   // Switch settings travel together.
   typedef struct packed {
      logic repeat_guard;
      logic [3:0] irq_sel;
      logic [3:0] mode_sel;
   } cists_switches_s;

endpackage

// File: hdl/cists_status_enc.sv
`timescale 1ns/1ps
// ============================================================================
// Status encoder: bus participation and error-counter level to a status code.
module cists_status_enc (
   input wire logic bus_active_i,          // Module takes part in bus traffic.
   input wire logic [7:0] rec_i,           // Receive error counter.
   input wire logic [7:0] tec_i,           // Transmit error counter.
   output logic [31:0] code_o              // Four-value status code.
);

   logic high_err;

   // Either counter at the warning level makes the error half of the code.
   assign high_err = (rec_i >= cists_pkg::ERR_WARN_LEVEL) || (tec_i >= cists_pkg::ERR_WARN_LEVEL);

   // Pick the code from the two conditions.
   always_comb begin
      if (bus_active_i && !high_err) begin
         code_o = cists_pkg::STAT_ACTIVE_OK;    // [RL1]
      end else if (bus_active_i) begin
         code_o = cists_pkg::STAT_ACTIVE_ERR;   // [RL2]
      end else if (!high_err) begin
         code_o = cists_pkg::STAT_IDLE_OK;      // [RL3]
      end else begin
         code_o = cists_pkg::STAT_IDLE_ERR;     // [RL4]
      end
   end

endmodule

// File: hdl/cists_cmd.sv
`timescale 1ns/1ps
// Behaviour
// RL1: Status reads 0000 when on the bus and both error counters are below 96.
// RL2: Status reads 0001 when on the bus and an error counter is 96 or more.
// RL3: Status reads 0002 when off the bus and both error counters are below 96.
// RL4: Status reads 0003 when off the bus and an error counter is 96 or more.
// RL5: Command 30 returns the firmware identity and version.
// RL6: With repeat-read at 0 a data read returns the last captured value even if already read.
// RL7: With repeat-read at 1 a data read of an already read value returns minus 99999.
// RL8: Interrupt switch 0 disables, 1 pulse, 2 fast, 8 low-power standby; 3 to 7 undefined.
// RL9: Writing 9 to the interrupt or mode switch leaves that switch unchanged.
// RL10: Mode switch selects listen-only, transmit-once, self-reception, retransmit and self-test modes.
// RL11: Mode switch value 7 is in effect after power-up.
// RL12: Read-switches returns every switch as set, ignoring unchanged-code writes.
// ============================================================================
// Command handler: host commands arrive as Wishbone writes to the command
// register; the answer is read back from the result register.
module cists_cmd #(
   parameter logic [15:0] FW_ID = 16'hA5C3,   // Firmware identity, arbitrary value.
   parameter logic [15:0] FW_VERSION = 16'h0102 // Firmware version, arbitrary value.
) (
   input wire logic clk_i,                  // System clock, 100 MHz.
   input wire logic rst_i,                  // Synchronous reset, active high.
   input wire logic wb_cyc_i,               // Wishbone cycle.
   input wire logic wb_stb_i,               // Wishbone strobe.
   input wire logic wb_we_i,                // Wishbone write enable.
   input wire logic [7:0] wb_adr_i,         // Wishbone byte address.
   input wire logic [3:0] wb_sel_i,         // Wishbone byte selects.
   input wire logic [31:0] wb_dat_i,        // Wishbone write data.
   output logic [31:0] wb_dat_o,            // Wishbone read data.
   output logic wb_ack_o,                   // Wishbone acknowledge.
   input wire logic cap_valid_i,            // Pulse: new captured data value.
   input wire logic [31:0] cap_data_i,      // Captured data value.
   output logic [3:0] irq_sel_o,            // Interrupt switch setting.
   output logic standby_o,                  // Low-power standby request.
   output logic [3:0] mode_sel_o,           // Controller operating mode.
   output logic repeat_guard_o              // Repeat-read switch.
);

   // =========================================================================
   // Declarations.
   cists_pkg::cists_switches_s sw;
   cists_pkg::cists_switches_s next_sw;
   logic [31:0] bus_state;
   logic [31:0] result;
   logic [31:0] next_result;
   logic [31:0] next_rdata;
   logic [31:0] last_value;
   logic fresh;
   logic standby;
   logic [31:0] status_code;
   logic bus_req;
   logic rd_req;
   logic wr_cmd;
   logic wr_bus_state;
   logic wr_data_in;
   logic set_cmd;
   logic rd_data_cmd;
   logic stale_read;
   logic [31:0] merged;
   logic [7:0] cmd_code;
   logic [3:0] req_irq;
   logic [3:0] req_mode;

   // Apply byte selects to a stored word.
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // =========================================================================
   // Helper functions and elaboration checks.

   // A write request that hits one register. Every write decode goes through
   // here, so the qualifiers that make a request live stay the same for all.
   function automatic logic write_hit(input logic req, input logic we, input logic [7:0] adr,
                                      input logic [7:0] target);
      return req && we && (adr == target);
   endfunction

   // Take a four-bit switch field out of a command word.
   function automatic logic [3:0] switch_field(input logic [31:0] word, input int lsb);
      return word[lsb +: 4];
   endfunction

   // Lay the switches out as the set command takes them, so that software can
   // write back what it read after changing one field. Unused bits read zero.
   function automatic logic [31:0] switch_word(input cists_pkg::cists_switches_s s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[cists_pkg::SW_REPEAT_BIT] = s.repeat_guard;
      w[cists_pkg::SW_IRQ_LSB +: 4] = s.irq_sel;
      w[cists_pkg::SW_MODE_LSB +: 4] = s.mode_sel;
      return w;
   endfunction

   // The word layout lives in the package. A command word field that runs off
   // its word or lands on another field, or a transmit counter that runs off the
   // bus state word, would corrupt settings without any other sign, so such a
   // layout is refused when the design is built.
   if (cists_pkg::CMD_CODE_LSB + 8 > 32) begin
      $error("Command code does not fit in the command word.");
   end
   if (cists_pkg::SW_REPEAT_BIT < cists_pkg::CMD_CODE_LSB + 8) begin
      $error("Repeat-read bit overlaps the command code.");
   end
   if (cists_pkg::SW_IRQ_LSB <= cists_pkg::SW_REPEAT_BIT) begin
      $error("Interrupt field overlaps the repeat-read bit.");
   end
   if (cists_pkg::SW_MODE_LSB < cists_pkg::SW_IRQ_LSB + 4) begin
      $error("Mode field overlaps the interrupt field.");
   end
   if (cists_pkg::SW_MODE_LSB + 4 > 32) begin
      $error("Mode field does not fit in the command word.");
   end
   if (cists_pkg::ST_TEC_LSB + 8 > 32) begin
      $error("Transmit error counter does not fit in the bus state word.");
   end
   if ($bits(cists_pkg::cists_switches_s) != 9) begin
      $error("Switches register expects nine bits of settings.");
   end
   if (cists_pkg::ERR_WARN_LEVEL == 8'h00) begin
      $error("A zero warning level would flag every error counter.");
   end

   // =========================================================================
   // Bus decode. Ack is registered, so a request is taken only while ack is
   // low: without that guard a held write would be taken a second time in the
   // cycle in which ack stands.
   //
   // Timing seen by a master, one edge at a time:
   //   edge 0: cyc, stb and the request appear;
   //   edge 1: the request is taken, a write lands, read data is loaded;
   //   edge 2: the master sees ack high and releases the request;
   //   edge 3: ack is low again and a new request may be taken.
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rd_req = bus_req && !wb_we_i;
   assign wr_cmd = write_hit(bus_req, wb_we_i, wb_adr_i, cists_pkg::ADDR_CMD);
   assign wr_bus_state = write_hit(bus_req, wb_we_i, wb_adr_i, cists_pkg::ADDR_BUS_STATE);
   assign wr_data_in = write_hit(bus_req, wb_we_i, wb_adr_i, cists_pkg::ADDR_DATA_IN);

   // Unselected bytes of a command write count as zero, so a byte-wide write
   // of the code alone sends a command with every switch field at zero.
   assign merged = merge_bytes(32'h0000_0000, wb_dat_i, wb_sel_i);
   assign cmd_code = merged[cists_pkg::CMD_CODE_LSB +: 8];
   assign set_cmd = wr_cmd && (cmd_code == cists_pkg::CMD_SET_SW);
   assign rd_data_cmd = wr_cmd && (cmd_code == cists_pkg::CMD_READ_DATA);
   assign req_irq = switch_field(merged, cists_pkg::SW_IRQ_LSB);
   assign req_mode = switch_field(merged, cists_pkg::SW_MODE_LSB);

   // Acknowledge every access one cycle after the request is taken.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // =========================================================================
   // Bus state word: participation flag and both error counters, written by
   // the controller side. Byte selects let one counter change on its own.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state <= 32'h0000_0000;
      end else if (wr_bus_state) begin
         bus_state <= merge_bytes(bus_state, wb_dat_i, wb_sel_i);
      end
   end

   // The status code is decoded from the stored word, so a status command
   // always reports the counters as they stand at the edge it is taken.
   cists_status_enc u_status (
      .bus_active_i(bus_state[cists_pkg::ST_ACTIVE_BIT]),
      .rec_i(bus_state[cists_pkg::ST_REC_LSB +: 8]),
      .tec_i(bus_state[cists_pkg::ST_TEC_LSB +: 8]),
      .code_o(status_code)
   );

   // =========================================================================
   // Captured value and its fresh flag. A capture in the same cycle as a data
   // read wins: the read answers with the old value and the new one is kept
   // as fresh, so it is not lost.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_value <= 32'h0000_0000;
         fresh <= 1'b0;
      end else if (cap_valid_i) begin
         last_value <= cap_data_i;
         fresh <= 1'b1;
      end else if (wr_data_in) begin
         last_value <= merge_bytes(last_value, wb_dat_i, wb_sel_i);
         fresh <= 1'b1;
      end else if (rd_data_cmd) begin
         fresh <= 1'b0;
      end
   end

   // =========================================================================
   // Next switch settings. The repeat-read bit has no unchanged code and is
   // always written; the other two fields keep their value on code 9.
   always_comb begin
      next_sw = sw;
      if (set_cmd) begin
         next_sw.repeat_guard = merged[cists_pkg::SW_REPEAT_BIT];   // [RL6] [RL7]
         if (req_irq != cists_pkg::SW_KEEP) begin                     // [RL9]
            next_sw.irq_sel = req_irq;                                // [RL8]
         end
         if (req_mode != cists_pkg::SW_KEEP) begin                    // [RL9]
            next_sw.mode_sel = req_mode;                              // [RL10]
         end
      end
   end

   // Switch registers. Undefined codes are stored as written; what they mean
   // is left to the logic that reads the outputs.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sw.repeat_guard <= cists_pkg::REPEAT_RESET;
         sw.irq_sel <= cists_pkg::IRQ_OFF;
         sw.mode_sel <= cists_pkg::MODE_POWERUP;                      // [RL11]
      end else begin
         sw <= next_sw;
      end
   end

   // Standby has its own flop, loaded from the next interrupt setting, so it
   // changes on the same edge as the switch and the pin sees no decode glitch.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         standby <= (cists_pkg::IRQ_OFF == cists_pkg::IRQ_STANDBY);
      end else begin
         standby <= (next_sw.irq_sel == cists_pkg::IRQ_STANDBY);     // [RL8]
      end
   end

   // Switch outputs straight from the registers.
   assign irq_sel_o = sw.irq_sel;                                    // [RL8]
   assign standby_o = standby;                                       // [RL8]
   assign mode_sel_o = sw.mode_sel;                                  // [RL10]
   assign repeat_guard_o = sw.repeat_guard;                          // [RL6] [RL7]

   // =========================================================================
   // The stale marker replaces an already read value only while the
   // repeat-read switch asks for it; otherwise the host gets the last value
   // again, as often as it asks.
   assign stale_read = !fresh && sw.repeat_guard;

   // Next answer. It only changes when a command is written; unknown commands
   // answer zero so that software never reads a leftover answer as valid.
   always_comb begin
      next_result = result;
      if (wr_cmd) begin
         unique case (cmd_code)
            cists_pkg::CMD_STATUS: next_result = status_code;         // [RL1] [RL2] [RL3] [RL4]
            cists_pkg::CMD_VERSION: next_result = {FW_ID, FW_VERSION}; // [RL5]
            cists_pkg::CMD_READ_SW: next_result = switch_word(sw);     // [RL12]
            cists_pkg::CMD_READ_DATA: begin
               if (stale_read) begin
                  next_result = cists_pkg::STALE_MARK;                // [RL7]
               end else begin
                  next_result = last_value;                           // [RL6]
               end
            end
            default: next_result = 32'h0000_0000;
         endcase
      end
   end

   // Result register: the answer stands until the next command replaces it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result <= 32'h0000_0000;
      end else begin
         result <= next_result;
      end
   end

   // =========================================================================
   // Read data for the register addressed. Unmapped addresses read zero; the
   // switches register pads the packed settings up to a word.
   always_comb begin
      unique case (wb_adr_i)
         cists_pkg::ADDR_RESULT: next_rdata = result;
         cists_pkg::ADDR_BUS_STATE: next_rdata = bus_state;
         cists_pkg::ADDR_DATA_IN: next_rdata = last_value;
         cists_pkg::ADDR_SWITCHES: next_rdata = {23'h000000, sw};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data is loaded with ack and then holds until the next read, so a
   // slow master still finds it after ack has dropped.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd_req) begin
         wb_dat_o <= next_rdata;
      end
   end

endmodule

// File: dv/cists_cmd_asserts.sv
`timescale 1ns/1ps
// ============================================================================
// Port checker for the command handler; it only watches and never drives.
module cists_cmd_chk (
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Reset.
   input wire logic wb_cyc_i, // Cycle.
   input wire logic wb_stb_i, // Strobe.
   input wire logic wb_we_i, // Write.
   input wire logic [7:0] wb_adr_i, // Address.
   input wire logic [3:0] wb_sel_i, // Selects.
   input wire logic [31:0] wb_dat_i, // Write data.
   input wire logic [31:0] wb_dat_o, // Read data.
   input wire logic wb_ack_o, // Acknowledge.
   input wire logic cap_valid_i, // Capture pulse.
   input wire logic [31:0] cap_data_i, // Capture value.
   input wire logic [3:0] irq_sel_o, // Interrupt switch.
   input wire logic standby_o, // Standby.
   input wire logic [3:0] mode_sel_o, // Mode switch.
   input wire logic repeat_guard_o // Repeat switch.
);
   // One clock domain, so clocking and reset are given once for all checks.
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A full-word set-switches command taken at this edge; partial selects are left out on purpose.
   sequence set_cmd;
      wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i == 4'hF && wb_dat_i[7:0] == 8'h20;
   endsequence
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i) && $past(wb_cyc_i)) else $error("stray ack");
   power_up_a: assert property ($past(rst_i) |-> mode_sel_o == 4'h7 && irq_sel_o == 4'h0 && !repeat_guard_o)
      else $error("bad reset switches");
   standby_dec_a: assert property (standby_o == (irq_sel_o == 4'h8)) else $error("standby wrong");
   irq_set_a: assert property (set_cmd ##0 wb_dat_i[15:12] != 4'h9 |=> irq_sel_o == $past(wb_dat_i[15:12]))
      else $error("irq not set");
   irq_keep_a: assert property (set_cmd ##0 wb_dat_i[15:12] == 4'h9 |=> $stable(irq_sel_o))
      else $error("irq moved");
   mode_set_a: assert property (set_cmd ##0 wb_dat_i[19:16] != 4'h9 |=> mode_sel_o == $past(wb_dat_i[19:16]))
      else $error("mode not set");
   mode_keep_a: assert property (set_cmd ##0 wb_dat_i[19:16] == 4'h9 |=> $stable(mode_sel_o))
      else $error("mode moved");
   repeat_set_a: assert property (set_cmd |=> repeat_guard_o == $past(wb_dat_i[8]))
      else $error("repeat wrong");
endmodule
bind cists_cmd cists_cmd_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .cap_valid_i, .cap_data_i, .irq_sel_o, .standby_o, .mode_sel_o, .repeat_guard_o);

// File: dv/cists_host.sv
`timescale 1ns/1ps
// ============================================================================
// Host model: a classic single-cycle bus master that waits for any latency.
module cists_host (
   input wire logic clk_i, // Clock.
   input wire logic wb_ack_i, // Acknowledge.
   input wire logic [31:0] wb_dat_i, // Read data.
   output logic wb_cyc_o, // Cycle.
   output logic wb_stb_o, // Strobe.
   output logic wb_we_o, // Write.
   output logic [7:0] wb_adr_o, // Address.
   output logic [3:0] wb_sel_o, // Selects.
   output logic [31:0] wb_dat_o // Write data.
);
   // Idle bus from time zero; write data idles to a non-zero pattern.
   initial begin
      wb_cyc_o = 1'h0;
      wb_stb_o = 1'h0;
      wb_we_o = 1'h0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'hFFFF_FFFF;
   end
   // One transfer; the request holds until the edge that sees ack, then drops.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      wb_cyc_o <= 1'h1;
      wb_stb_o <= 1'h1;
      wb_we_o <= w;
      wb_adr_o <= a;
      wb_sel_o <= 4'hF;
      wb_dat_o <= d;
      do @(posedge clk_i); while (wb_ack_i !== 1'h1);
      r = wb_dat_i;
      wb_cyc_o <= 1'h0;
      wb_stb_o <= 1'h0;
      wb_dat_o <= ~d;
   endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
`define chk(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
   $display("mismatch %0t got %h want %h", $time, (a), (e)); end end
// ============================================================================
// Bench: host commands in sequence, each status, version, switch and data answer compared with its expected value.
module tb_top;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic cyc, stb, we, ack, stby, rep;
   logic cap_v = 1'h0;
   logic [7:0] adr;
   logic [3:0] sel, irq, mode;
   logic [31:0] wdat, rdat, r;
   logic [31:0] cap_d = 32'h0;
   int mismatches = 0;
   int checks_done = 0;
   logic [31:0] st[4] = '{32'h0000_5F01, 32'h0060_0001, 32'h005F_5F00, 32'h0000_6000};
   logic [3:0] iq[7] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h1, 4'h2, 4'h0};
   // The 100 MHz clock.
   always #5 clk = ~clk;
   cists_cmd #(.FW_ID(16'h5A01), .FW_VERSION(16'h0203)) u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .cap_valid_i(cap_v), .cap_data_i(cap_d), .irq_sel_o(irq), .standby_o(stby),
      .mode_sel_o(mode), .repeat_guard_o(rep));
   cists_host u_host (.clk_i(clk), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb),
      .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
   // Prints the counts and the verdict, then ends the run.
   task conclude;
      $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Issues a command and leaves its answer in r.
   task run(input logic [31:0] c);
      u_host.xfer(1'h1, 8'h00, c, r);
      u_host.xfer(1'h0, 8'h04, 32'h0, r);
   endtask
   // Watchdog: the whole sequence needs well under a thousand cycles.
   initial begin
      #100000;
      mismatches++;
      conclude();
   end
   // Main sequence.
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      run(32'h21);
      `chk(r, 32'h0007_0000)
      for (int i = 0; i < 4; i++) begin
         u_host.xfer(1'h1, 8'h08, st[i], r);
         run(32'h1D);
         `chk(r, 32'(i))
      end
      run(32'h1E);
      `chk(r, 32'h5A01_0203)
      for (int i = 0; i < 7; i++) begin
         run({12'h000, 4'(i), iq[i], 12'h020});
         `chk(mode, 4'(i))
         `chk(irq, iq[i])
         `chk(stby, iq[i] == 4'h8)
      end
      run(32'h0009_9120);
      run(32'h21);
      `chk(r, 32'h0006_0100)
      `chk(rep, 1'h1)
      u_host.xfer(1'h0, 8'h10, 32'h0, r);
      `chk(r, 32'h0000_0106)
      u_host.xfer(1'h1, 8'h0C, 32'h0000_1234, r);
      run(32'h01);
      `chk(r, 32'h0000_1234)
      run(32'h01);
      `chk(r, 32'hFFFE_7961)
      @(posedge clk);
      cap_v <= 1'h1;
      cap_d <= 32'h0000_CAFE;
      @(posedge clk);
      cap_v <= 1'h0;
      run(32'h0009_9020);
      `chk(rep, 1'h0)
      run(32'h01);
      `chk(r, 32'h0000_CAFE)
      run(32'h01);
      `chk(r, 32'h0000_CAFE)
      u_host.xfer(1'h0, 8'h14, 32'h0, r);
      `chk(r, 32'h0)
      conclude();
   end
endmodule
